/* common/sleep_pkg.sv */
package sleep_pkg;

    // Mode select codes
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // Reset value of the controller state register
    localparam logic [3:0] STATE_RESET = 4'h1;

    // Controller states, one-hot
    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_IDLE = 4'h2,
        ST_STANDBY = 4'h4,
        ST_POWER_DOWN = 4'h8
    } sleep_state_t;

    // Control bits written by software
    typedef struct packed {
        logic sleep_enable_bit;
        logic [1:0] sleep_mode_select;
    } control_register_a_t;

    // Wake request inputs, each already qualified by its own enable
    typedef struct packed {
        logic pin_irq;
        logic pin_change_irq;
        logic two_wire_addr_match;
        logic uart_start_of_frame_irq;
        logic rtc_irq;
        logic timer_counter_b_irq;
        logic other_irq;
    } wake_sources_t;

    // Run-in-standby configuration for peripherals that can keep running
    typedef struct packed {
        logic uart;
        logic rtc;
        logic timer_counter_b;
        logic adc;
        logic other;
    } run_in_standby_bit_t;

    // Clock and enable outputs towards the clock controller and peripherals
    typedef struct packed {
        logic cpu_clock_run;
        logic uart_run;
        logic rtc_run;
        logic timer_counter_b_run;
        logic adc_run;
        logic other_per_run;
        logic periodic_interrupt_timer_run;
        logic watchdog_timer_run;
    } domain_run_t;

endpackage : sleep_pkg

/* dv/cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic clk,
    output logic sleep_instr,
    output sleep_pkg::control_register_a_t control_register_a
);
    // Idle core at time zero
    initial begin
        sleep_instr = 1'b0;
        control_register_a = '0;
    end
    // Control bits written first, then one sleep instruction pulse
    task automatic exec_sleep(input logic en, input logic [1:0] mode);
        control_register_a = {en, mode};
        @(posedge clk);
        #1 sleep_instr = 1'b1;
        @(posedge clk);
        #1 sleep_instr = 1'b0;
    endtask : exec_sleep
endmodule : cpu_core_model

/* dv/sleep_asserts.sv */
`timescale 1ns/1ps
module sleep_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input sleep_pkg::control_register_a_t control_register_a,
    input wire logic sleep_instr,
    input wire logic debug_break,
    input sleep_pkg::wake_sources_t wake_sources,
    input sleep_pkg::run_in_standby_bit_t run_in_standby_bit,
    input wire logic sleeping,
    input wire logic wake_pulse,
    input wire logic [1:0] active_mode,
    input sleep_pkg::domain_run_t domain_run
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic take;
    logic [1:0] md;
    // Accepted sleep request and its mode
    assign take = !sleeping && sleep_instr && control_register_a.sleep_enable_bit;
    assign md = control_register_a.sleep_mode_select;
    sequence s_wake;
        ##1 (!sleeping && wake_pulse);
    endsequence
    enter_sleep_a: assert property (take |=> sleeping) else $error("no sleep");
    noop_instr_a: assert property (!sleeping && sleep_instr && !control_register_a.sleep_enable_bit
        |=> !sleeping) else $error("slept");
    debug_wake_a: assert property (sleeping && debug_break |-> s_wake) else $error("dbg");
    wake_cause_a: assert property ($fell(sleeping) |-> wake_pulse) else $error("pulse");
    active_all_a: assert property (!sleeping |-> domain_run == 8'hff && active_mode == 2'h0)
        else $error("active");
    idle_run_a: assert property (take && md inside {2'h0, 2'h3} |=> domain_run == 8'h7f
        && active_mode == 2'h0) else $error("idle");
    pd_run_a: assert property (take && md == 2'h2 |=> domain_run == 8'h03
        && active_mode == 2'h2) else $error("pd");
    stby_run_a: assert property (take && md == 2'h1 |=> active_mode == 2'h1
        && domain_run == {1'b0, $past(run_in_standby_bit), 2'h3}) else $error("stby");
    pd_hold_a: assert property (sleeping && active_mode == 2'h2 && !debug_break
        && !wake_sources.pin_change_irq && !wake_sources.two_wire_addr_match
        |=> sleeping) else $error("pd wake");
    stby_hold_a: assert property (sleeping && active_mode == 2'h1 && !debug_break
        && wake_sources inside {7'h00, 7'h01} |=> sleeping) else $error("stby wake");
    idle_wake_a: assert property (sleeping && active_mode == 2'h0 && wake_sources.other_irq
        |-> s_wake) else $error("idle wake");
endmodule : sleep_asserts
bind sleep_controller_unit sleep_asserts sleep_asserts_i (.clk(clk), .arst_n(arst_n),
    .control_register_a(control_register_a), .sleep_instr(sleep_instr),
    .debug_break(debug_break), .wake_sources(wake_sources),
    .run_in_standby_bit(run_in_standby_bit), .sleeping(sleeping),
    .wake_pulse(wake_pulse), .active_mode(active_mode), .domain_run(domain_run));

/* dv/tb_sleep_controller_unit.sv */
`timescale 1ns/1ps
module tb_sleep_controller_unit;
    logic clk, arst_n, sleep_instr, debug_break, sleeping, wake_pulse;
    logic [1:0] active_mode;
    sleep_pkg::control_register_a_t control_register_a;
    sleep_pkg::wake_sources_t wake_sources;
    sleep_pkg::run_in_standby_bit_t run_in_standby_bit;
    sleep_pkg::domain_run_t domain_run;
    int fails = 0;
    int samples_checked = 0;
    cpu_core_model cpu_core_model_i (.clk(clk), .sleep_instr(sleep_instr),
        .control_register_a(control_register_a));
    sleep_controller_unit sleep_controller_unit_i (.clk(clk), .arst_n(arst_n),
        .control_register_a(control_register_a), .sleep_instr(sleep_instr),
        .debug_break(debug_break), .wake_sources(wake_sources),
        .run_in_standby_bit(run_in_standby_bit), .sleeping(sleeping),
        .wake_pulse(wake_pulse), .active_mode(active_mode), .domain_run(domain_run));
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        fails++;
        close_out();
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic t_modes();
        logic [7:0] run [4];
        run = '{8'h7f, 8'h2b, 8'h03, 8'h7f};
        for (int m = 0; m < 4; m++) begin
            cpu_core_model_i.exec_sleep(1'b1, 2'(m));
            check("mode", {sleeping, active_mode}, (m == 3) ? 8'h04 : 8'(m + 4));
            check("run", domain_run, run[m]);
            debug_break = 1'b1;
            tick();
            debug_break = 1'b0;
            check("wake_sleeping", sleeping, 8'h00);
            check("wake_run", domain_run, 8'hff);
            check("wake_mode", active_mode, 8'h00);
            check("wake_pulse", wake_pulse, 8'h01);
            tick();
            check("pulse_end", wake_pulse, 8'h00);
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_noop();
        cpu_core_model_i.exec_sleep(1'b0, 2'h2);
        tick();
        check("sleeping", sleeping, 8'h00);
        $display("t_noop done");
    endtask : t_noop
    task automatic t_wake(input logic [1:0] m, input logic [6:0] bad, input logic [6:0] good);
        cpu_core_model_i.exec_sleep(1'b1, m);
        wake_sources = bad;
        tick();
        tick();
        check("sleeping", sleeping, 8'h01);
        wake_sources = good;
        tick();
        check("wake", {sleeping, wake_pulse}, 8'h01);
        wake_sources = '0;
        $display("t_wake done");
    endtask : t_wake
    task automatic t_reset();
        cpu_core_model_i.exec_sleep(1'b1, 2'h2);
        repeat (4) tick();
        check("sleeping", sleeping, 8'h01);
        arst_n = 1'b0;
        tick();
        check("reset_sleeping", sleeping, 8'h00);
        check("reset_run", domain_run, 8'hff);
        check("reset_pulse", wake_pulse, 8'h00);
        check("reset_mode", active_mode, 8'h00);
        arst_n = 1'b1;
        tick();
        $display("t_reset done");
    endtask : t_reset
    task automatic close_out();
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    // Reset, then the scenarios in turn
    initial begin
        arst_n = 1'b0;
        debug_break = 1'b0;
        wake_sources = '0;
        run_in_standby_bit = 5'h0a;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        t_modes();
        t_noop();
        t_wake(2'h2, 7'h4f, 7'h10);
        t_wake(2'h1, 7'h09, 7'h02);
        t_reset();
        close_out();
    end
endmodule : tb_sleep_controller_unit

/* verilog/sleep_controller_unit.sv */
`timescale 1ns/1ps

// What this block does
// - One active mode, three sleep modes
// - Sleep needs enable bit plus sleep instruction
// - Interrupt wake returns active, resume after sleep
// - Any reset ends sleep
// - Reset in sleep restarts at reset vector
// - Register file, SRAM, peripherals keep contents
// - Debug break forces return to active
// - Run-time debugging leaves behaviour unchanged
// - No enabled interrupt means sleep until reset or debug break
// - Idle stops CPU, peripherals run, all wake
// - Standby peripherals follow run-in-standby bits
// - ADC may convert autonomously in standby
// - Standby wakes only on listed sources
// - Power-down keeps only watchdog and periodic timer
// - Power-down wakes on pin change, address match
// - Clocked from the peripheral clock
module sleep_controller_unit (
    input wire logic clk,
    input wire logic arst_n,
    input sleep_pkg::control_register_a_t control_register_a,
    input wire logic sleep_instr,
    input wire logic debug_break,
    input sleep_pkg::wake_sources_t wake_sources,
    input sleep_pkg::run_in_standby_bit_t run_in_standby_bit,
    output logic sleeping,
    output logic wake_pulse,
    output logic [1:0] active_mode,
    output sleep_pkg::domain_run_t domain_run
);

    // Decodes the mode select field; the reserved code falls back to Idle
    function automatic sleep_pkg::sleep_state_t mode_to_state(input logic [1:0] sel);
        sleep_pkg::sleep_state_t st;
        st = sleep_pkg::ST_IDLE;
        unique case (sel)
            sleep_pkg::MODE_IDLE: st = sleep_pkg::ST_IDLE;
            sleep_pkg::MODE_STANDBY: st = sleep_pkg::ST_STANDBY;
            sleep_pkg::MODE_POWER_DOWN: st = sleep_pkg::ST_POWER_DOWN;
            sleep_pkg::MODE_RESERVED: st = sleep_pkg::ST_IDLE;
        endcase
        return st;
    endfunction : mode_to_state

    // Maps a state back to the mode code it reports
    function automatic logic [1:0] state_to_mode(input sleep_pkg::sleep_state_t st);
        logic [1:0] m;
        m = sleep_pkg::MODE_IDLE;
        unique case (st)
            sleep_pkg::ST_STANDBY: m = sleep_pkg::MODE_STANDBY;
            sleep_pkg::ST_POWER_DOWN: m = sleep_pkg::MODE_POWER_DOWN;
            default: m = sleep_pkg::MODE_IDLE;
        endcase
        return m;
    endfunction : state_to_mode

    // Idle keeps every peripheral running, so any qualified source wakes
    function automatic logic idle_wake(
        input sleep_pkg::wake_sources_t src
    );
        logic hit;
        hit = 1'b0;
        hit = hit | src.pin_irq;
        hit = hit | src.pin_change_irq;
        hit = hit | src.two_wire_addr_match;
        hit = hit | src.uart_start_of_frame_irq;
        hit = hit | src.rtc_irq;
        hit = hit | src.timer_counter_b_irq;
        hit = hit | src.other_irq;
        return hit;
    endfunction : idle_wake

    // Standby wakes only on the listed sources; uart and rtc need their run bit
    function automatic logic standby_wake(
        input sleep_pkg::wake_sources_t src,
        input sleep_pkg::run_in_standby_bit_t rsb
    );
        logic hit;
        logic uart_hit;
        logic rtc_hit;
        uart_hit = src.uart_start_of_frame_irq & rsb.uart;
        rtc_hit = src.rtc_irq & rsb.rtc;
        hit = 1'b0;
        hit = hit | src.pin_irq;
        hit = hit | src.pin_change_irq;
        hit = hit | src.two_wire_addr_match;
        hit = hit | src.timer_counter_b_irq;
        hit = hit | uart_hit;
        hit = hit | rtc_hit;
        return hit;
    endfunction : standby_wake

    // Power-down wakes only on a pin change or an address match
    function automatic logic power_down_wake(
        input sleep_pkg::wake_sources_t src
    );
        logic hit;
        hit = 1'b0;
        hit = hit | src.pin_change_irq;
        hit = hit | src.two_wire_addr_match;
        return hit;
    endfunction : power_down_wake

    // Everything runs while code executes
    function automatic sleep_pkg::domain_run_t active_domains();
        sleep_pkg::domain_run_t dr;
        dr.cpu_clock_run = 1'b1;
        dr.uart_run = 1'b1;
        dr.rtc_run = 1'b1;
        dr.timer_counter_b_run = 1'b1;
        dr.adc_run = 1'b1;
        dr.other_per_run = 1'b1;
        // Watchdog and periodic timer never stop
        dr.periodic_interrupt_timer_run = 1'b1;
        dr.watchdog_timer_run = 1'b1;
        return dr;
    endfunction : active_domains

    // Idle stops only the CPU clock
    function automatic sleep_pkg::domain_run_t idle_domains();
        sleep_pkg::domain_run_t dr;
        dr.cpu_clock_run = 1'b0;
        dr.uart_run = 1'b1;
        dr.rtc_run = 1'b1;
        dr.timer_counter_b_run = 1'b1;
        dr.adc_run = 1'b1;
        dr.other_per_run = 1'b1;
        // Watchdog and periodic timer never stop
        dr.periodic_interrupt_timer_run = 1'b1;
        dr.watchdog_timer_run = 1'b1;
        return dr;
    endfunction : idle_domains

    // Standby peripherals follow their own run bits; the ADC may convert alone
    function automatic sleep_pkg::domain_run_t standby_domains(
        input sleep_pkg::run_in_standby_bit_t rsb
    );
        sleep_pkg::domain_run_t dr;
        dr.cpu_clock_run = 1'b0;
        dr.uart_run = rsb.uart;
        dr.rtc_run = rsb.rtc;
        dr.timer_counter_b_run = rsb.timer_counter_b;
        dr.adc_run = rsb.adc;
        dr.other_per_run = rsb.other;
        // Watchdog and periodic timer never stop
        dr.periodic_interrupt_timer_run = 1'b1;
        dr.watchdog_timer_run = 1'b1;
        return dr;
    endfunction : standby_domains

    // Power-down keeps only the watchdog and the periodic timer
    function automatic sleep_pkg::domain_run_t power_down_domains();
        sleep_pkg::domain_run_t dr;
        dr.cpu_clock_run = 1'b0;
        dr.uart_run = 1'b0;
        dr.rtc_run = 1'b0;
        dr.timer_counter_b_run = 1'b0;
        dr.adc_run = 1'b0;
        dr.other_per_run = 1'b0;
        // Watchdog and periodic timer never stop
        dr.periodic_interrupt_timer_run = 1'b1;
        dr.watchdog_timer_run = 1'b1;
        return dr;
    endfunction : power_down_domains

    // Controller state and its next value
    sleep_pkg::sleep_state_t state_q;
    sleep_pkg::sleep_state_t state_d;

    // One-cycle wake pulse
    logic wake_q;
    logic wake_d;

    // Reported mode code
    logic [1:0] mode_q;
    logic [1:0] mode_d;

    // Domain run enables
    sleep_pkg::domain_run_t run_q;
    sleep_pkg::domain_run_t run_d;

    // Decoded requests for this cycle
    logic wake_now;
    logic sleep_take;
    logic exit_take;

    // Wake qualification per sleep mode
    always_comb begin
        wake_now = 1'b0;
        unique case (state_q)
            sleep_pkg::ST_ACTIVE: begin
                wake_now = 1'b0;
            end
            sleep_pkg::ST_IDLE: begin
                wake_now = idle_wake(wake_sources);
            end
            sleep_pkg::ST_STANDBY: begin
                wake_now = standby_wake(wake_sources, run_in_standby_bit);
            end
            sleep_pkg::ST_POWER_DOWN: begin
                wake_now = power_down_wake(wake_sources);
            end
        endcase
    end

    // Sleep is taken only with the enable set
    assign sleep_take = sleep_instr & control_register_a.sleep_enable_bit;

    // A qualified wake source or a debug break ends any sleep mode
    assign exit_take = wake_now | debug_break;

    // State transitions; a debug break wakes any sleep mode
    always_comb begin
        state_d = state_q;
        wake_d = 1'b0;
        unique case (state_q)
            sleep_pkg::ST_ACTIVE: begin
                if (sleep_take) begin
                    state_d = mode_to_state(control_register_a.sleep_mode_select);
                end else begin
                    state_d = sleep_pkg::ST_ACTIVE; // Enable clear does nothing
                end
            end
            sleep_pkg::ST_IDLE: begin
                if (exit_take) begin
                    state_d = sleep_pkg::ST_ACTIVE;
                    wake_d = 1'b1;
                end
            end
            sleep_pkg::ST_STANDBY: begin
                if (exit_take) begin
                    state_d = sleep_pkg::ST_ACTIVE;
                    wake_d = 1'b1;
                end
            end
            sleep_pkg::ST_POWER_DOWN: begin
                // Without any enabled wake source only reset or a debug break leaves here
                if (exit_take) begin
                    state_d = sleep_pkg::ST_ACTIVE;
                    wake_d = 1'b1;
                end
            end
        endcase
    end

    // Controller state; reset always lands in active mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= sleep_pkg::sleep_state_t'(sleep_pkg::STATE_RESET);
            wake_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wake_q <= wake_d;
        end
    end

    // Domain run enables from the next state; only clocks gate, no state is cleared
    always_comb begin
        run_d = active_domains();
        unique case (state_d)
            sleep_pkg::ST_ACTIVE: begin
                run_d = active_domains();
            end
            sleep_pkg::ST_IDLE: begin
                run_d = idle_domains();
            end
            sleep_pkg::ST_STANDBY: begin
                run_d = standby_domains(run_in_standby_bit);
            end
            sleep_pkg::ST_POWER_DOWN: begin
                run_d = power_down_domains();
            end
        endcase
    end

    // Reported mode code follows the next state
    always_comb begin
        mode_d = state_to_mode(state_d);
    end

    // Registered outputs; gating clocks keeps contents intact
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= '1;
            mode_q <= sleep_pkg::MODE_IDLE;
        end else begin
            run_q <= run_d;
            mode_q <= mode_d;
        end
    end

    // Debug without a break never touches the state path
    assign sleeping = (state_q != sleep_pkg::ST_ACTIVE);
    assign wake_pulse = wake_q;
    assign active_mode = mode_q;
    assign domain_run = run_q;

endmodule : sleep_controller_unit
